// >>> logic/bec_erase_host.sv
`timescale 1ns/1ns
`default_nettype none
module bec_erase_host
  import bec_pkg::*;
#(
  parameter int ERASE_PULSE_CYCLES = ERASE_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // User control and status
  input wire logic start,
  output logic busy,
  output logic done,
  output logic fail,
  output logic already_blank,
  output logic [TALLY_W-1:0] pulse_tally,
  output logic [ADDR_W-1:0] verify_byte_address,
  // Programming supply
  output logic supply_on,
  input wire logic program_supply_high,
  // Flash pins
  output bec_pins_t flash_pins,
  input wire logic [DATA_W-1:0] flash_dq_in
);

  typedef enum logic [4:0] {
    S_IDLE = 5'b00000,
    S_SUPPLY = 5'b00001,
    S_BLANK = 5'b00010,
    S_PSETUP = 5'b00011,
    S_PWRITE = 5'b00100,
    S_PPULSE = 5'b00101,
    S_PVERIFY = 5'b00110,
    S_PSETTLE = 5'b00111,
    S_PREAD = 5'b01000,
    S_ESETUP = 5'b01001,
    S_EWRITE = 5'b01010,
    S_EPULSE = 5'b01011,
    S_EVERIFY = 5'b01100,
    S_ESETTLE = 5'b01101,
    S_EREAD = 5'b01110,
    S_RESET1 = 5'b01111,
    S_RESET2 = 5'b10000,
    S_FINISH = 5'b10001
  } bec_state_t;

  localparam logic [TIMER_W-1:0] ERASE_LD = TIMER_W'(ERASE_PULSE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SETTLE_LD = TIMER_W'(SETTLE_CYC - 1);
  localparam logic [TIMER_W-1:0] PROG_LD = TIMER_W'(PROG_PULSE_CYC - 1);

  // Build one bus request
  function automatic bec_req_t mk_req(input logic wr,
                                      input logic [ADDR_W-1:0] a,
                                      input logic [DATA_W-1:0] d);
    bec_req_t r;
    r.wr = wr;
    r.addr = a;
    r.data = d;
    return r;
  endfunction

  bec_state_t state_q, state_d;
  bec_req_t req_q, req_d;
  logic req_v_q, req_v_d;
  logic [TIMER_W-1:0] timer_q;
  logic timer_ld;
  logic [TIMER_W-1:0] timer_val;
  logic [ADDR_W-1:0] addr_q;
  logic addr_clr, addr_inc;
  logic [ADDR_W-1:0] addr_next;
  logic [TALLY_W-1:0] tally_q;
  logic tally_clr, tally_inc;
  logic [TRY_W-1:0] try_q;
  logic try_clr, try_inc;
  logic fail_pend_q, fail_set, blank_set;
  logic busy_q, done_q, fail_q, blank_q, supply_q;
  logic sup_meta_q, sup_sync_q;
  logic bus_ack;
  logic [DATA_W-1:0] bus_rdata;
  logic timer_zero, at_last;

  assign timer_zero = (timer_q == '0);
  assign at_last = (addr_q == LAST_ADDR);
  assign addr_next = addr_q + 1'b1;

  // Supply status arrives from a pin: two stages before use
  always_ff @(posedge clk) begin
    sup_meta_q <= program_supply_high;
    sup_sync_q <= sup_meta_q;
  end

  // Sequencing of the whole erase flow
  always_comb begin
    state_d = state_q;
    req_v_d = 1'b0;
    req_d = req_q;
    timer_ld = 1'b0;
    timer_val = '0;
    addr_clr = 1'b0;
    addr_inc = 1'b0;
    tally_clr = 1'b0;
    tally_inc = 1'b0;
    try_clr = 1'b0;
    try_inc = 1'b0;
    fail_set = 1'b0;
    blank_set = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (start) begin
          state_d = S_SUPPLY;
        end
      end
      S_SUPPLY: begin
        if (sup_sync_q) begin // Supply up before anything else
          addr_clr = 1'b1;
          tally_clr = 1'b1;
          req_v_d = 1'b1;
          req_d = mk_req(1'b0, FIRST_ADDR, ZERO_BYTE);
          state_d = S_BLANK;
        end
      end
      S_BLANK: begin
        if (bus_ack) begin
          if (bus_rdata != ERASED_BYTE) begin
            // Data present: pre-program to zero first
            addr_clr = 1'b1;
            try_clr = 1'b1;
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, FIRST_ADDR, CMD_PROG_SETUP);
            state_d = S_PSETUP;
          end else if (at_last) begin
            blank_set = 1'b1; // Already erased, skip erasure
            state_d = S_FINISH;
          end else begin
            addr_inc = 1'b1;
            req_v_d = 1'b1;
            req_d = mk_req(1'b0, addr_next, ZERO_BYTE);
          end
        end
      end
      S_PSETUP: begin
        if (bus_ack) begin
          req_v_d = 1'b1;
          req_d = mk_req(1'b1, addr_q, ZERO_BYTE);
          state_d = S_PWRITE;
        end
      end
      S_PWRITE: begin
        if (bus_ack) begin
          try_inc = 1'b1;
          timer_ld = 1'b1;
          timer_val = PROG_LD;
          state_d = S_PPULSE;
        end
      end
      S_PPULSE: begin
        if (timer_zero) begin
          req_v_d = 1'b1;
          req_d = mk_req(1'b1, addr_q, CMD_PROG_VERIFY);
          state_d = S_PVERIFY;
        end
      end
      S_PVERIFY: begin
        if (bus_ack) begin
          timer_ld = 1'b1;
          timer_val = SETTLE_LD;
          state_d = S_PSETTLE;
        end
      end
      S_PSETTLE: begin
        if (timer_zero) begin
          req_v_d = 1'b1;
          req_d = mk_req(1'b0, addr_q, ZERO_BYTE);
          state_d = S_PREAD;
        end
      end
      S_PREAD: begin
        if (bus_ack) begin
          if (bus_rdata == ZERO_BYTE && at_last) begin
            // Whole array at zero: begin erase set-up
            addr_clr = 1'b1;
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, FIRST_ADDR, CMD_ERASE);
            state_d = S_ESETUP;
          end else if (bus_rdata == ZERO_BYTE) begin
            addr_inc = 1'b1;
            try_clr = 1'b1;
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, addr_next, CMD_PROG_SETUP);
            state_d = S_PSETUP;
          end else if (try_q >= MAX_PROG_PULSES) begin
            fail_set = 1'b1;
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, addr_q, CMD_RESET);
            state_d = S_RESET1;
          end else begin
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, addr_q, CMD_PROG_SETUP);
            state_d = S_PSETUP;
          end
        end
      end
      S_ESETUP: begin
        if (bus_ack) begin
          req_v_d = 1'b1;
          req_d = mk_req(1'b1, addr_q, CMD_ERASE); // Second 20H
          state_d = S_EWRITE;
        end
      end
      S_EWRITE: begin
        if (bus_ack) begin
          // Ack follows the strobe's rise: pulse timing starts
          tally_inc = 1'b1;
          timer_ld = 1'b1;
          timer_val = ERASE_LD;
          state_d = S_EPULSE;
        end
      end
      S_EPULSE: begin
        if (timer_zero) begin
          // Verify write ends the pulse
          req_v_d = 1'b1;
          req_d = mk_req(1'b1, addr_q, CMD_ERASE_VERIFY);
          state_d = S_EVERIFY;
        end
      end
      S_EVERIFY: begin
        if (bus_ack) begin
          timer_ld = 1'b1;
          timer_val = SETTLE_LD;
          state_d = S_ESETTLE;
        end
      end
      S_ESETTLE: begin
        if (timer_zero) begin
          req_v_d = 1'b1;
          req_d = mk_req(1'b0, addr_q, ZERO_BYTE);
          state_d = S_EREAD;
        end
      end
      S_EREAD: begin
        if (bus_ack) begin
          if (bus_rdata == ERASED_BYTE && at_last) begin
            // All verified: leave verify mode with reset
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, addr_q, CMD_RESET);
            state_d = S_RESET1;
          end else if (bus_rdata == ERASED_BYTE) begin
            addr_inc = 1'b1; // Next address in order
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, addr_next, CMD_ERASE_VERIFY);
            state_d = S_EVERIFY;
          end else if (tally_q >= MAX_ERASE_PULSES) begin
            fail_set = 1'b1; // Pulse budget spent
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, addr_q, CMD_RESET);
            state_d = S_RESET1;
          end else begin
            // Erase again; pointer kept at failing byte
            req_v_d = 1'b1;
            req_d = mk_req(1'b1, addr_q, CMD_ERASE);
            state_d = S_ESETUP;
          end
        end
      end
      S_RESET1: begin
        if (bus_ack) begin
          req_v_d = 1'b1;
          req_d = mk_req(1'b1, addr_q, CMD_RESET); // Back to read
          state_d = S_RESET2;
        end
      end
      S_RESET2: begin
        if (bus_ack) begin
          state_d = S_FINISH;
        end
      end
      S_FINISH: begin
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // State and bus request
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      req_v_q <= 1'b0;
      req_q <= '0;
    end else begin
      state_q <= state_d;
      req_v_q <= req_v_d;
      req_q <= req_d;
    end
  end

  // Pulse and settle timer; one counter serves every wait
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_q <= '0;
    end else if (timer_ld) begin
      timer_q <= timer_val;
    end else if (!timer_zero) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  // Address pointer, erase tally and program tries
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_q <= '0;
      tally_q <= '0;
      try_q <= '0;
    end else begin
      if (addr_clr) begin
        addr_q <= FIRST_ADDR; // Verify starts at zero
      end else if (addr_inc) begin
        addr_q <= addr_next;
      end
      if (tally_clr) begin
        tally_q <= '0;
      end else if (tally_inc) begin
        tally_q <= tally_q + 1'b1;
      end
      if (try_clr) begin
        try_q <= '0;
      end else if (try_inc) begin
        try_q <= try_q + 1'b1;
      end
    end
  end

  // User status; done and fail are one-cycle pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_pend_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      blank_q <= 1'b0;
      supply_q <= 1'b0;
    end else begin
      done_q <= (state_q == S_FINISH) && !fail_pend_q;
      fail_q <= (state_q == S_FINISH) && fail_pend_q;
      if (state_q == S_IDLE && start) begin
        busy_q <= 1'b1;
        supply_q <= 1'b1;
        fail_pend_q <= 1'b0;
        blank_q <= 1'b0;
      end else if (state_q == S_FINISH) begin
        busy_q <= 1'b0;
        supply_q <= 1'b0; // Drop supply only after read mode restored
      end
      if (fail_set) begin
        fail_pend_q <= 1'b1;
      end
      if (blank_set) begin
        blank_q <= 1'b1;
      end
    end
  end

  bec_bus_cycle u_bus (
    .clk(clk),
    .reset(reset),
    .req_valid(req_v_q),
    .req(req_q),
    .ack(bus_ack),
    .rdata(bus_rdata),
    .pins(flash_pins),
    .dq_in(flash_dq_in)
  );

  assign busy = busy_q;
  assign done = done_q;
  assign fail = fail_q;
  assign already_blank = blank_q;
  assign pulse_tally = tally_q;
  assign verify_byte_address = addr_q;
  assign supply_on = supply_q;

endmodule
`default_nettype wire

// >>> common/bec_pkg.sv
`default_nettype none
package bec_pkg;

  // Array geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] FIRST_ADDR = 15'h0000;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 15'h7fff;

  // Command codes and expected byte values
  localparam logic [DATA_W-1:0] CMD_ERASE = 8'h20;
  localparam logic [DATA_W-1:0] CMD_ERASE_VERIFY = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [DATA_W-1:0] CMD_PROG_VERIFY = 8'hc0;
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hff;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // Pulse limits
  localparam int TALLY_W = 10;
  localparam logic [TALLY_W-1:0] MAX_ERASE_PULSES = 10'h3e8;
  localparam int TRY_W = 5;
  localparam logic [TRY_W-1:0] MAX_PROG_PULSES = 5'h19;

  // Timing, figures in their own units
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_PULSE_MS = 10;
  localparam int SETTLE_US = 6;
  localparam int PROG_PULSE_US = 10;
  localparam int ADDR_SETUP_NS = 20;
  localparam int WE_LOW_NS = 50;
  localparam int WR_HOLD_NS = 20;
  localparam int READ_ACCESS_NS = 100;

  // Least times, rounded up to whole cycles
  localparam int ERASE_PULSE_CYC =
    (ERASE_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC =
    (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_PULSE_CYC =
    (PROG_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_SETUP_CYC =
    (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HOLD_CYC = (WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TIMER_W = 24;
  localparam int BUS_CNT_W = 4;

  // One bus cycle request
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bec_req_t;

  // Flash control, address and data-out pins
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } bec_pins_t;

endpackage
`default_nettype wire

// >>> logic/bec_bus_cycle.sv
`timescale 1ns/1ns
`default_nettype none
module bec_bus_cycle
  import bec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Request side
  input wire logic req_valid,
  input wire bec_req_t req,
  output logic ack,
  output logic [DATA_W-1:0] rdata,
  // Flash pins
  output bec_pins_t pins,
  input wire logic [DATA_W-1:0] dq_in
);

  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_SETUP = 3'b001,
    B_STROBE = 3'b010,
    B_HOLD = 3'b011,
    B_READ = 3'b100
  } bec_bus_st_t;

  localparam logic [BUS_CNT_W-1:0] SETUP_LD = BUS_CNT_W'(ADDR_SETUP_CYC - 1);
  localparam logic [BUS_CNT_W-1:0] STROBE_LD = BUS_CNT_W'(WE_LOW_CYC - 1);
  localparam logic [BUS_CNT_W-1:0] HOLD_LD = BUS_CNT_W'(WR_HOLD_CYC - 1);
  localparam logic [BUS_CNT_W-1:0] READ_LD = BUS_CNT_W'(READ_CYC - 1);

  bec_bus_st_t st_q;
  logic [BUS_CNT_W-1:0] cnt_q;
  logic [DATA_W-1:0] dq_meta_q, dq_sync_q;
  bec_pins_t pins_q;
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic phase_end;

  assign phase_end = (cnt_q == '0);

  // Data pins come from another domain: two stages before use
  always_ff @(posedge clk) begin
    dq_meta_q <= dq_in;
    dq_sync_q <= dq_meta_q;
  end

  // Phase sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= B_IDLE;
      cnt_q <= '0;
    end else begin
      case (st_q)
        B_IDLE: begin
          if (req_valid) begin
            st_q <= req.wr ? B_SETUP : B_READ;
            cnt_q <= req.wr ? SETUP_LD : READ_LD;
          end
        end
        B_SETUP: begin
          if (!phase_end) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            st_q <= B_STROBE;
            cnt_q <= STROBE_LD;
          end
        end
        B_STROBE: begin
          if (!phase_end) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            st_q <= B_HOLD;
            cnt_q <= HOLD_LD;
          end
        end
        B_HOLD, B_READ: begin
          if (!phase_end) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            st_q <= B_IDLE;
          end
        end
        default: st_q <= B_IDLE;
      endcase
    end
  end

  // Pin drive; chip select falls before write strobe so the strobe is
  // always the later falling edge and latches the address
  always_ff @(posedge clk) begin
    if (reset) begin
      pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0,
                  dq_out: '0, dq_oe: 1'b0};
    end else if (st_q == B_IDLE && req_valid) begin
      pins_q.ce_n <= 1'b0;
      pins_q.oe_n <= req.wr; // Output drive held high on writes
      pins_q.addr <= req.addr;
      pins_q.dq_out <= req.data;
      pins_q.dq_oe <= req.wr;
    end else if (phase_end) begin
      if (st_q == B_SETUP) begin
        pins_q.we_n <= 1'b0; // Address latched here
      end else if (st_q == B_STROBE) begin
        pins_q.we_n <= 1'b1; // Data latched, command acts
      end else if (st_q == B_HOLD || st_q == B_READ) begin
        pins_q.ce_n <= 1'b1;
        pins_q.oe_n <= 1'b1;
        pins_q.dq_oe <= 1'b0;
      end
    end
  end

  // Completion pulse and read capture
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= phase_end && (st_q == B_HOLD || st_q == B_READ);
      if (phase_end && st_q == B_READ) begin
        rdata_q <= dq_sync_q;
      end
    end
  end

  assign pins = pins_q;
  assign ack = ack_q;
  assign rdata = rdata_q;

endmodule
`default_nettype wire

// >>> bench/bec_erase_host_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module bec_erase_host_assertions
  import bec_pkg::*;
#(
  parameter int ERASE_PULSE_CYCLES = ERASE_PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Status seen by the user
  input wire logic start,
  input wire logic busy,
  input wire logic already_blank,
  input wire logic [ADDR_W-1:0] verify_byte_address,
  input wire logic supply_on,
  // Flash pins
  input wire bec_pins_t flash_pins
);
  logic we_q;
  logic [DATA_W-1:0] last_q;
  logic erasing_q;
  int cnt_q;
  wire logic rise = flash_pins.we_n && !we_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Strobe history and last command byte
  always_ff @(posedge clk) begin
    we_q <= reset | flash_pins.we_n;
    if (reset) last_q <= 8'h00;
    else if (rise) last_q <= flash_pins.dq_out;
  end

  // Age of the current pulse; wide enough for any real run
  always_ff @(posedge clk) begin
    if (reset || rise) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
    if (reset) erasing_q <= 1'b0;
    else if (rise) erasing_q <= last_q == CMD_ERASE &&
      flash_pins.dq_out == CMD_ERASE;
  end

  wr_states_a: assert property (
    !flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n &&
    flash_pins.dq_oe) else $error("write strobe in a bad pin state");
  strobe_width_a: assert property (
    $fell(flash_pins.we_n) |-> (!flash_pins.we_n)[*5] ##1 flash_pins.we_n)
    else $error("write strobe width wrong");
  addr_setup_a: assert property (
    $fell(flash_pins.we_n) |-> $past(!flash_pins.ce_n, 2) &&
    $stable(flash_pins.addr)) else $error("address not set up");
  bus_idle_a: assert property (
    !supply_on |-> flash_pins.ce_n) else $error("bus used without supply");
  start_take_a: assert property (
    start && !busy |=> busy && supply_on) else $error("start not taken");
  erase_time_a: assert property (
    $fell(flash_pins.we_n) && erasing_q |-> cnt_q >= ERASE_PULSE_CYCLES)
    else $error("erase pulse cut short");
  erase_end_a: assert property (
    rise && erasing_q |-> flash_pins.dq_out == CMD_ERASE_VERIFY)
    else $error("erase not ended by verify");
  verify_addr_a: assert property (
    rise && flash_pins.dq_out == CMD_ERASE_VERIFY |->
    flash_pins.addr == verify_byte_address) else $error("verify address");
  reset_cmd_a: assert property (
    $fell(supply_on) && !already_blank |-> last_q == CMD_RESET)
    else $error("run ended without reset command");
endmodule

bind bec_erase_host bec_erase_host_assertions #(
  .ERASE_PULSE_CYCLES(ERASE_PULSE_CYCLES)
) bec_erase_host_assertions_inst (
  .clk(clk), .reset(reset), .start(start), .busy(busy),
  .already_blank(already_blank), .verify_byte_address(verify_byte_address),
  .supply_on(supply_on), .flash_pins(flash_pins)
);
`default_nettype wire

// >>> bench/bec_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module bec_flash_model
  import bec_pkg::*;
#(
  parameter int ACCESS_NS = 40
) (
  // Supply level and stuck-cell fault
  input wire logic supply_high,
  input wire logic stuck,
  // Flash pins
  input wire bec_pins_t pins,
  output logic [DATA_W-1:0] dq
);
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] cmd = 8'h00;
  logic [ADDR_W-1:0] a_lat = 15'h0000;
  logic [ADDR_W-1:0] pa = 15'h0000;
  logic staged = 1'b0;
  logic prog = 1'b0;
  wire logic [DATA_W-1:0] rd;

  // Programmed contents, byte 0 never blank
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'h5a ^ i[7:0];
  end

  // Address taken at the later falling strobe
  always @(negedge pins.we_n or negedge pins.ce_n) begin
    if (!pins.we_n && !pins.ce_n) a_lat = pins.addr;
  end

  // Supply loss drops back to read; data taken at strobe rise, only in
  // a valid write state. One process owns the command state.
  always @(posedge pins.we_n or negedge supply_high) begin
    if (!supply_high) begin
      cmd = ZERO_BYTE;
      staged = 1'b0;
      prog = 1'b0;
    end else if (!pins.ce_n && pins.oe_n) begin
      if (prog) begin
        pa = a_lat;
        if (!stuck) mem[a_lat] = mem[a_lat] & pins.dq_out;
      end else begin
        cmd = pins.dq_out;
      end
      if (staged && pins.dq_out == CMD_ERASE) begin
        // Whole pulse lands at once, so no stop timer can be outrun
        for (int i = 0; i < 32768; i++) mem[i] = ERASED_BYTE;
      end
      staged = !staged && !prog && pins.dq_out == CMD_ERASE;
      prog = !prog && pins.dq_out == CMD_PROG_SETUP;
    end
  end

  // Margin read of the latched byte in verify modes
  assign rd = cmd == CMD_ERASE_VERIFY ? mem[a_lat] :
    cmd == CMD_PROG_VERIFY ? mem[pa] : mem[pins.addr];
  // Unselected bus shows the inverse, never a held value
  assign #ACCESS_NS dq = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
endmodule
`default_nettype wire

// >>> bench/tb_bec_erase_host.sv
`timescale 1ns/1ns
`default_nettype none
module tb_bec_erase_host
  import bec_pkg::*;
;
  localparam int PULSE = 50;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic supply_high = 1'b0;
  logic stuck = 1'b0;
  logic busy, done, fail, already_blank, supply_on;
  logic [TALLY_W-1:0] pulse_tally;
  logic [ADDR_W-1:0] verify_byte_address;
  bec_pins_t pins;
  logic [DATA_W-1:0] dq;
  logic [31:0] seed = 32'h4405;
  int mismatches = 0;
  int samples_checked = 0;
  int n_done = 0;
  int n_fail = 0;
  logic [22:0] wq[$];
  logic [ADDR_W-1:0] rq[$];

  bec_erase_host #(.ERASE_PULSE_CYCLES(PULSE)) bec_erase_host_inst (
    .clk(clk), .reset(reset), .start(start), .busy(busy), .done(done),
    .fail(fail), .already_blank(already_blank), .pulse_tally(pulse_tally),
    .verify_byte_address(verify_byte_address), .supply_on(supply_on),
    .program_supply_high(supply_high), .flash_pins(pins), .flash_dq_in(dq)
  );
  bec_flash_model bec_flash_model_inst (
    .supply_high(supply_high), .stuck(stuck), .pins(pins), .dq(dq)
  );

  always #5 clk = ~clk;

  // Bus trace and pulse counts for ordering checks
  always @(posedge pins.we_n) begin
    if (reset === 1'b0) wq.push_back({pins.addr, pins.dq_out});
  end
  always @(posedge pins.oe_n) begin
    if (reset === 1'b0) rq.push_back(pins.addr);
  end
  always @(posedge clk) begin
    if (done === 1'b1) n_done++;
    if (fail === 1'b1) n_fail++;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [22:0] wr(input logic [14:0] a,
                                     input logic [7:0] d);
    return {a, d};
  endfunction
  function automatic int writes_of(input logic [7:0] d);
    int c;
    c = 0;
    foreach (wq[i]) if (wq[i][7:0] == d) c++;
    return c;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse_start;
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
  endtask
  // Everything quiet, strobes inactive; address and data of the last
  // cycle stand until the next one begins
  task automatic idle_check(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d);
    check(busy, 1'b0);
    check(supply_on, 1'b0);
    check(pulse_tally, 10'h000);
    check(pins, {3'h7, a, d, 1'b0});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hang well past the longest run
  initial begin
    tick(90000);
    mismatches++;
    conclude();
  end

  initial begin
    int n;
    tick(4);
    reset <= 1'b0;
    tick(1);
    idle_check(FIRST_ADDR, ZERO_BYTE);
    // Supply held low for a random span: no access may begin
    pulse_start();
    seed = xs(seed);
    tick(50 + seed[7:0]);
    check(supply_on, 1'b1);
    check(busy, 1'b1);
    check(wq.size() + rq.size(), 0);
    $display("test supply_wait done");
    // Supply up: blank check stops at byte 0, preprogramming begins
    supply_high <= 1'b1;
    for (n = 0; n < 9000 && wq.size() < 5; n++) tick(1);
    check(rq[0], 15'h0000);
    check(rq.size(), 2);
    check(wq[0][7:0], CMD_PROG_SETUP);
    check(wq[1], wr(15'h0000, ZERO_BYTE));
    check(wq[2][7:0], CMD_PROG_VERIFY);
    check(wq[3][7:0], CMD_PROG_SETUP);
    check(wq[4], wr(15'h0001, ZERO_BYTE));
    check(writes_of(CMD_ERASE), 0);
    // Reset in mid-run returns everything to rest
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    idle_check(FIRST_ADDR, ZERO_BYTE);
    $display("test preprogram done");
    // Cells refuse to program: try limit, then the reset pair
    stuck <= 1'b1;
    wq.delete();
    rq.delete();
    pulse_start();
    seed = xs(seed);
    tick(20 + seed[9:0]);
    pulse_start();
    for (n = 0; n < 60000 && n_fail == 0; n++) tick(1);
    tick(10);
    check(n_fail, 1);
    check(n_done, 0);
    // Bytes 0 and 1 kept their zeros from the cut run: one try each,
    // then byte 2 spends the whole try budget
    check(writes_of(CMD_PROG_SETUP), MAX_PROG_PULSES + 2);
    check(verify_byte_address, 15'h0002);
    check(writes_of(CMD_ERASE), 0);
    check(wq[wq.size()-1][7:0], CMD_RESET);
    check(wq[wq.size()-2][7:0], CMD_RESET);
    check(already_blank, 1'b0);
    idle_check(15'h0002, CMD_RESET);
    $display("test program_limit done");
    conclude();
  end
endmodule
`default_nettype wire
